// *** inc/tmc_pkg.sv ***
// constants and types of the 16-bit timer/event counter with preload
package tmc_pkg;

    // ==========================================
    // register offsets
    localparam logic [7:0] TMC_OFS_CNT_HIGH = 8'h20;
    localparam logic [7:0] TMC_OFS_CNT_LOW = 8'h21;
    localparam logic [7:0] TMC_OFS_CTRL = 8'h22;
    localparam logic [7:0] TMC_OFS_PRE_HIGH = 8'h23;
    localparam logic [7:0] TMC_OFS_PRE_LOW = 8'h24;
    localparam logic [7:0] TMC_OFS_CFG = 8'h25;
    localparam logic [7:0] TMC_OFS_IRQ = 8'h26;

    // ==========================================
    // field positions
    localparam int TMC_CTRL_MODE_LSB = 6'h05;
    localparam int TMC_CTRL_RUN_BIT = 6'h04;
    localparam int TMC_CTRL_EDGE_BIT = 6'h03;
    localparam int TMC_CFG_CHANNEL_SELECT_BIT = 6'h07;
    localparam int TMC_CFG_BSRC_BIT = 6'h06;
    localparam int TMC_CFG_ADC_BIT = 6'h01;
    localparam int TMC_CFG_OVSRC_BIT = 6'h00;
    localparam int TMC_IRQ_FLAG_BIT = 6'h04;

    // ==========================================
    // reset values and limits
    localparam logic [1:0] TMC_MODE_RESET = 2'h0;
    localparam logic TMC_RUN_RESET = 1'h0;
    localparam logic TMC_EDGE_RESET = 1'h1;
    localparam logic [7:0] TMC_CFG_RESET = 8'h00;
    localparam logic [7:0] TMC_BYTE_RESET = 8'h00;
    localparam logic [15:0] TMC_CNT_RESET = 16'h0000;
    localparam logic [15:0] TMC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TMC_CNT_WRAP = 16'h0000;

    // ==========================================
    // modes and pulse measurement states
    typedef enum logic [1:0] {
        TMC_MODE_UNUSED = 2'h0,
        TMC_MODE_EVENT = 2'h1,
        TMC_MODE_TIMER = 2'h2,
        TMC_MODE_PULSE = 2'h3
    } tmc_mode_t;

    typedef enum logic [2:0] {
        TMC_PW_ARM = 3'h1,
        TMC_PW_MEAS = 3'h2,
        TMC_PW_DONE = 3'h4
    } tmc_pw_state_t;

endpackage

// *** rtl/tmc_count16.sv ***
// 16-bit up-counter with load and overflow reload
`timescale 1ns/1ps
module tmc_count16 (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic inc,
    input wire logic [15:0] reload_val,
    // state
    output logic [15:0] q,
    output logic ovf
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
    } tmc_cnt_state_t;

    tmc_cnt_state_t s_reg;
    tmc_cnt_state_t s_next;

    assign ovf = inc & ~load & (s_reg.cnt == TMC_CNT_MAX);
    assign q = s_reg.cnt;

    // a load wins over counting in the same cycle
    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.cnt = load_val;
        end else if (ovf) begin
            s_next.cnt = reload_val;
        end else if (inc) begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg.cnt <= TMC_CNT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // tmc_count16

// *** rtl/tmc_edge.sv ***
// rising and falling edge detection on synchronous inputs
`timescale 1ns/1ps
module tmc_edge #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // inputs and edge pulses
    input wire logic [W-1:0] sig,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [W-1:0] prev;
        logic valid;
    } tmc_edge_state_t;

    tmc_edge_state_t s_reg;
    tmc_edge_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.prev = sig;
        s_next.valid = 1'h1;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // no edges reported in the first cycle after reset
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign rise[i] = s_reg.valid & sig[i] & ~s_reg.prev[i];
            assign fall[i] = s_reg.valid & ~sig[i] & s_reg.prev[i];
        end
    endgenerate

endmodule // tmc_edge

// *** rtl/tmc_top.sv ***
// timer/event counter with preload, pulse-width mode and converter mode
`timescale 1ns/1ps

// Overview of operation
// - select bit 0 makes one 16-bit timer
// - preload low buffered, high loads both
// - counter high read latches low byte
// - counter reads live, preload writes start value
// - mode field picks event, timer, pulse
// - run bit enables counting
// - event edge: 1 falling, 0 rising
// - pulse edge select picks start/stop polarity
// - count to FFFFH, reload, set flag
// - one pulse measured, then hold result
// - pulse start needs a transition
// - pulse overflow reloads and sets flag
// - pulse end or converter-mode overflow clears run; else software
// - stopped preload write also loads counter if select bit 0
// - counter high read blocks counting
// - pulse width counted in system clocks
// - channel select picks RC input
// - select bit 1 makes two counters
module tmc_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RD_DATA,
    // oscillator inputs
    input wire logic RC_CLOCK_INPUT_ZERO,
    input wire logic RC_CLOCK_INPUT_ONE,
    input wire logic INTERNAL_RC_CLOCK,
    // status
    output logic OVERFLOW_REQUEST_FLAG,
    output logic COUNT_RUN
);
    import tmc_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        tmc_mode_t mode;
        logic run;
        logic edge_sel;
        logic [7:0] cfg;
        logic flag;
        logic [7:0] pre_low_wbuf;
        logic [7:0] cnt_low_wbuf;
        logic [7:0] cnt_low_rbuf;
        logic [7:0] pre_low_rbuf;
        logic [7:0] rd_data;
        tmc_pw_state_t pw;
    } tmc_top_state_t;

    localparam tmc_top_state_t TMC_TOP_RESET = '{
        mode: TMC_MODE_UNUSED,
        run: TMC_RUN_RESET,
        edge_sel: TMC_EDGE_RESET,
        cfg: TMC_CFG_RESET,
        flag: 1'h0,
        pre_low_wbuf: TMC_BYTE_RESET,
        cnt_low_wbuf: TMC_BYTE_RESET,
        cnt_low_rbuf: TMC_BYTE_RESET,
        pre_low_rbuf: TMC_BYTE_RESET,
        rd_data: TMC_BYTE_RESET,
        pw: TMC_PW_ARM
    };

    tmc_top_state_t s_reg;
    tmc_top_state_t s_next;

    // ==========================================
    // address decode
    logic wr_cnt_hi;
    logic wr_cnt_lo;
    logic wr_ctrl;
    logic wr_pre_hi;
    logic wr_pre_lo;
    logic wr_cfg;
    logic wr_irq;
    logic rd_cnt_hi;
    logic rd_pre_hi;

    always_comb begin
        wr_cnt_hi = 1'h0;
        wr_cnt_lo = 1'h0;
        wr_ctrl = 1'h0;
        wr_pre_hi = 1'h0;
        wr_pre_lo = 1'h0;
        wr_cfg = 1'h0;
        wr_irq = 1'h0;
        if (ADDR == TMC_OFS_CNT_HIGH) begin
            wr_cnt_hi = WR_STB;
        end else if (ADDR == TMC_OFS_CNT_LOW) begin
            wr_cnt_lo = WR_STB;
        end else if (ADDR == TMC_OFS_CTRL) begin
            wr_ctrl = WR_STB;
        end else if (ADDR == TMC_OFS_PRE_HIGH) begin
            wr_pre_hi = WR_STB;
        end else if (ADDR == TMC_OFS_PRE_LOW) begin
            wr_pre_lo = WR_STB;
        end else if (ADDR == TMC_OFS_CFG) begin
            wr_cfg = WR_STB;
        end else if (ADDR == TMC_OFS_IRQ) begin
            wr_irq = WR_STB;
        end
    end

    assign rd_cnt_hi = RD_STB & (ADDR == TMC_OFS_CNT_HIGH);
    assign rd_pre_hi = RD_STB & (ADDR == TMC_OFS_PRE_HIGH);

    // ==========================================
    // input selection and edges
    logic adc_mode;
    logic ext_in;
    logic [1:0] rise;
    logic [1:0] fall;
    logic ext_rise;
    logic ext_fall;
    logic int_rise;

    assign adc_mode = s_reg.cfg[TMC_CFG_ADC_BIT];
    assign ext_in = s_reg.cfg[TMC_CFG_CHANNEL_SELECT_BIT] ? RC_CLOCK_INPUT_ONE
                                                 : RC_CLOCK_INPUT_ZERO;

    tmc_edge #(
        .W(2)
    ) u_edge (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .sig({INTERNAL_RC_CLOCK, ext_in}),
        .rise(rise),
        .fall(fall)
    );

    assign ext_rise = rise[0];
    assign ext_fall = fall[0];
    assign int_rise = rise[1];

    // ==========================================
    // pulse edges
    logic pw_start;
    logic pw_stop;

    // transitions only, never levels
    assign pw_start = s_reg.edge_sel ? ext_rise : ext_fall;
    assign pw_stop = s_reg.edge_sel ? ext_fall : ext_rise;

    // ==========================================
    // counting enables
    logic inc_a;
    logic inc_b;
    logic hold_a;
    logic hold_b;
    logic b_src_edge;

    // a counter high-byte read freezes that counter for the cycle
    assign hold_a = rd_cnt_hi;
    assign hold_b = rd_pre_hi & adc_mode;
    assign b_src_edge = s_reg.cfg[TMC_CFG_BSRC_BIT] ? ext_rise : int_rise;

    always_comb begin
        inc_a = 1'h0;
        if (adc_mode) begin
            inc_a = s_reg.run;
        end else begin
            case (s_reg.mode)
                TMC_MODE_EVENT: begin
                    inc_a = s_reg.run & (s_reg.edge_sel ? ext_fall : ext_rise);
                end
                TMC_MODE_TIMER: begin
                    inc_a = s_reg.run;
                end
                TMC_MODE_PULSE: begin
                    // system clocks while the level lasts
                    inc_a = s_reg.run & (s_reg.pw == TMC_PW_MEAS) & ~pw_stop;
                end
                default: begin
                    inc_a = 1'h0;
                end
            endcase
        end
        inc_a = inc_a & ~hold_a;
    end

    assign inc_b = adc_mode & s_reg.run & b_src_edge & ~hold_b;

    // ==========================================
    // counter and preload
    logic [15:0] cnt_q;
    logic [15:0] pre_q;
    logic ovf_a;
    logic ovf_b;
    logic load_a;
    logic [15:0] load_a_val;
    logic [15:0] reload_a_val;

    // stopped, outside converter mode: preload write also loads the counter there
    assign load_a = wr_cnt_hi | (wr_pre_hi & ~s_reg.run & ~adc_mode);
    assign load_a_val = wr_cnt_hi ? {WR_DATA, s_reg.cnt_low_wbuf}
                                  : {WR_DATA, s_reg.pre_low_wbuf};
    assign reload_a_val = adc_mode ? TMC_CNT_WRAP : pre_q;

    tmc_count16 u_cnt_a (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .load(load_a),
        .load_val(load_a_val),
        .inc(inc_a),
        .reload_val(reload_a_val),
        .q(cnt_q),
        .ovf(ovf_a)
    );

    // preload register, which counts as the second counter in converter mode
    tmc_count16 u_cnt_b (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .load(wr_pre_hi),
        .load_val({WR_DATA, s_reg.pre_low_wbuf}),
        .inc(inc_b),
        .reload_val(TMC_CNT_WRAP),
        .q(pre_q),
        .ovf(ovf_b)
    );

    // ==========================================
    // overflow event
    logic ovf_evt;

    always_comb begin
        if (adc_mode) begin
            ovf_evt = s_reg.cfg[TMC_CFG_OVSRC_BIT] ? ovf_b : ovf_a;
        end else begin
            ovf_evt = ovf_a;
        end
    end

    // ==========================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.rd_data = TMC_BYTE_RESET;

        // write side
        if (wr_cnt_lo) begin
            s_next.cnt_low_wbuf = WR_DATA;
        end
        if (wr_pre_lo) begin
            s_next.pre_low_wbuf = WR_DATA;
        end
        if (wr_cfg) begin
            s_next.cfg = WR_DATA;
        end
        if (wr_irq) begin
            s_next.flag = WR_DATA[TMC_IRQ_FLAG_BIT];
        end
        if (ovf_evt) begin
            s_next.flag = 1'h1;
        end

        // pulse measurement sequence
        case (s_reg.pw)
            TMC_PW_ARM: begin
                if (s_reg.run && s_reg.mode == TMC_MODE_PULSE && !adc_mode && pw_start) begin
                    s_next.pw = TMC_PW_MEAS;
                end
            end
            TMC_PW_MEAS: begin
                if (!s_reg.run || s_reg.mode != TMC_MODE_PULSE || adc_mode) begin
                    s_next.pw = TMC_PW_ARM;
                end else if (pw_stop) begin
                    s_next.pw = TMC_PW_DONE;
                    s_next.run = 1'h0;
                end
            end
            TMC_PW_DONE: begin
                s_next.pw = TMC_PW_DONE;
            end
            default: begin
                s_next.pw = TMC_PW_ARM;
            end
        endcase

        // converter mode stops on the chosen overflow
        if (adc_mode && ovf_evt) begin
            s_next.run = 1'h0;
        end

        // software control write overrides the hardware stop
        if (wr_ctrl) begin
            s_next.mode = tmc_mode_t'(WR_DATA[TMC_CTRL_MODE_LSB +: 2]);
            s_next.run = WR_DATA[TMC_CTRL_RUN_BIT];
            s_next.edge_sel = WR_DATA[TMC_CTRL_EDGE_BIT];
            if (WR_DATA[TMC_CTRL_RUN_BIT]) begin
                s_next.pw = TMC_PW_ARM;
            end
        end

        // read side, data stands one cycle later
        if (RD_STB) begin
            if (ADDR == TMC_OFS_CNT_HIGH) begin
                s_next.rd_data = cnt_q[15:8];
                s_next.cnt_low_rbuf = cnt_q[7:0];
            end else if (ADDR == TMC_OFS_CNT_LOW) begin
                s_next.rd_data = s_reg.cnt_low_rbuf;
            end else if (ADDR == TMC_OFS_CTRL) begin
                s_next.rd_data = {1'h0, s_reg.mode, s_reg.run, s_reg.edge_sel, 3'h0};
            end else if (ADDR == TMC_OFS_PRE_HIGH) begin
                s_next.rd_data = pre_q[15:8];
                s_next.pre_low_rbuf = pre_q[7:0];
            end else if (ADDR == TMC_OFS_PRE_LOW) begin
                s_next.rd_data = s_reg.pre_low_rbuf;
            end else if (ADDR == TMC_OFS_CFG) begin
                s_next.rd_data = s_reg.cfg;
            end else if (ADDR == TMC_OFS_IRQ) begin
                s_next.rd_data = {3'h0, s_reg.flag, 4'h0};
            end else begin
                s_next.rd_data = TMC_BYTE_RESET;
            end
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            s_reg <= TMC_TOP_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // outputs
    assign RD_DATA = s_reg.rd_data;
    assign OVERFLOW_REQUEST_FLAG = s_reg.flag;
    assign COUNT_RUN = s_reg.run;

endmodule // tmc_top

// *** verification/tmc_rc_model.sv ***
// model of the external rc oscillator source
`timescale 1ns/1ps
module tmc_rc_model (
    // clock
    input wire logic clk,
    // burst command
    input wire logic go,
    input wire logic sel,
    input wire logic [3:0] ntog,
    input wire logic [7:0] half,
    // oscillator pins and status
    output logic rc0,
    output logic rc1,
    output logic busy
);
    logic lvl = 1'b0;
    logic [3:0] left = 4'h0;
    logic [7:0] wcnt = 8'h00;
    // unselected pin held low, level kept between bursts
    assign rc0 = sel ? 1'b0 : lvl;
    assign rc1 = sel ? lvl : 1'b0;
    assign busy = left != 4'h0;
    always @(posedge clk) begin
        if (go) begin
            left <= ntog;
            wcnt <= half;
        end else if (busy) begin
            if (wcnt == 8'h01) begin
                lvl <= ~lvl;
                left <= left - 4'h1;
                wcnt <= half;
            end else begin
                wcnt <= wcnt - 8'h01;
            end
        end
    end
endmodule // tmc_rc_model

// *** verification/tmc_top_sva.sv ***
// assertions on the ports of the timer/event counter
`timescale 1ns/1ps
module tmc_top_sva (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] RD_DATA,
    // oscillator inputs
    input wire logic RC_CLOCK_INPUT_ZERO,
    input wire logic RC_CLOCK_INPUT_ONE,
    input wire logic INTERNAL_RC_CLOCK,
    // status
    input wire logic OVERFLOW_REQUEST_FLAG,
    input wire logic COUNT_RUN
);
    import tmc_pkg::*;
    // ========================================
    // software view of mode and converter select
    logic [1:0] mode_q;
    logic adc_q;
    wire ctrl_wr = WR_STB && ADDR == TMC_OFS_CTRL;
    wire irq_wr = WR_STB && ADDR == TMC_OFS_IRQ;
    wire run_wr = WR_DATA[TMC_CTRL_RUN_BIT];
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            mode_q <= TMC_MODE_RESET;
            adc_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                mode_q <= WR_DATA[TMC_CTRL_MODE_LSB +: 2];
            end
            if (WR_STB && ADDR == TMC_OFS_CFG) begin
                adc_q <= WR_DATA[TMC_CFG_ADC_BIT];
            end
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);
    // ========================================
    // properties
    AST_RD_IDLE: assert property (!RD_STB |=> RD_DATA == 8'h00)
        else $error("read data not zero");
    AST_RD_UNMAPPED: assert property (RD_STB && ADDR > TMC_OFS_IRQ |=> RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    AST_RUN_WRITE: assert property (ctrl_wr |=> COUNT_RUN == $past(run_wr))
        else $error("run bit not written");
    AST_RUN_HOLD: assert property (COUNT_RUN && !ctrl_wr && !adc_q
        && mode_q != TMC_MODE_PULSE |=> COUNT_RUN) else $error("run cleared by itself");
    AST_FLAG_HOLD: assert property (OVERFLOW_REQUEST_FLAG && !irq_wr
        |=> OVERFLOW_REQUEST_FLAG) else $error("flag dropped");
    AST_FLAG_WRITE: assert property (irq_wr && WR_DATA[TMC_IRQ_FLAG_BIT]
        |=> OVERFLOW_REQUEST_FLAG) else $error("flag not set");
    AST_CTRL_READ: assert property (RD_STB && ADDR == TMC_OFS_CTRL |=>
        RD_DATA[6:4] == {mode_q, $past(COUNT_RUN)}) else $error("control readback");
    AST_IRQ_READ: assert property (RD_STB && ADDR == TMC_OFS_IRQ |=>
        RD_DATA[4] == $past(OVERFLOW_REQUEST_FLAG)) else $error("flag readback");
    COV_FLAG: cover property ($rose(OVERFLOW_REQUEST_FLAG));
    COV_PULSE_END: cover property ($fell(COUNT_RUN) && mode_q == TMC_MODE_PULSE);
    COV_UNMAPPED: cover property (RD_STB && ADDR > TMC_OFS_IRQ);
    COV_ADC_STOP: cover property ($fell(COUNT_RUN) && adc_q);
endmodule // tmc_top_sva

bind tmc_top tmc_top_sva u_sva (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .RC_CLOCK_INPUT_ZERO(RC_CLOCK_INPUT_ZERO), .RC_CLOCK_INPUT_ONE(RC_CLOCK_INPUT_ONE),
    .INTERNAL_RC_CLOCK(INTERNAL_RC_CLOCK), .OVERFLOW_REQUEST_FLAG(OVERFLOW_REQUEST_FLAG),
    .COUNT_RUN(COUNT_RUN));

// *** verification/tmc_top_test.sv ***
// self-checking bench for the timer/event counter
`timescale 1ns/1ps
module tmc_top_test;
    import tmc_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WR_DATA = 8'h00;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic [7:0] RD_DATA;
    logic rc0;
    logic rc1;
    logic flag;
    logic run;
    logic go = 1'b0;
    logic sel = 1'b0;
    logic [3:0] ntog = 4'h0;
    logic [7:0] half = 8'h01;
    logic busy;
    logic [7:0] b;
    logic [15:0] v;
    logic [15:0] w;
    int fails = 0;
    int checks_done = 0;
    tmc_top DUT (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RC_CLOCK_INPUT_ZERO(rc0),
        .RC_CLOCK_INPUT_ONE(rc1), .INTERNAL_RC_CLOCK(rc1),
        .OVERFLOW_REQUEST_FLAG(flag), .COUNT_RUN(run));
    tmc_rc_model u_rc (.clk(SYS_CLK), .go(go), .sel(sel), .ntog(ntog), .half(half),
        .rc0(rc0), .rc1(rc1), .busy(busy));
    initial begin
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    // ========================================
    // bus and helper tasks
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one strobe cycle then one idle cycle
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        WR_STB <= wr;
        RD_STB <= !wr;
        ADDR <= a;
        WR_DATA <= d;
        @(posedge SYS_CLK);
        WR_STB <= 1'b0;
        RD_STB <= 1'b0;
        #1 b = RD_DATA;
        @(posedge SYS_CLK);
    endtask
    task automatic rdc;
        acc(1'b0, TMC_OFS_CNT_HIGH, 8'h00);
        v[15:8] = b;
        acc(1'b0, TMC_OFS_CNT_LOW, 8'h00);
        v[7:0] = b;
    endtask
    task automatic rng(input logic [15:0] e);
        rdc;
        chk({15'h0000, v + 16'h0001 >= e && v <= e + 16'h0001}, 16'h0001);
    endtask
    task automatic ld(input logic [15:0] p);
        acc(1'b1, TMC_OFS_CTRL, 8'h08);
        acc(1'b1, TMC_OFS_PRE_LOW, p[7:0]);
        acc(1'b1, TMC_OFS_PRE_HIGH, p[15:8]);
    endtask
    task automatic burst(input logic s, input logic [3:0] n, input logic [7:0] h);
        sel <= s;
        ntog <= n;
        half <= h;
        go <= 1'b1;
        @(posedge SYS_CLK);
        go <= 1'b0;
        #1;
        repeat (250) if (busy) @(negedge SYS_CLK);
        repeat (4) @(posedge SYS_CLK);
    endtask
    // ========================================
    // scenarios
    task automatic t_regs;
        acc(1'b0, TMC_OFS_CTRL, 8'h00);
        chk({8'h00, b}, 16'h0008);
        acc(1'b0, TMC_OFS_CFG, 8'h00);
        chk({8'h00, b}, 16'h0000);
        acc(1'b0, 8'h30, 8'h00);
        chk({8'h00, b}, 16'h0000);
        acc(1'b1, TMC_OFS_IRQ, 8'h10);
        acc(1'b0, TMC_OFS_IRQ, 8'h00);
        chk({8'h00, b}, 16'h0010);
        acc(1'b1, TMC_OFS_IRQ, 8'h00);
        acc(1'b0, TMC_OFS_IRQ, 8'h00);
        chk({8'h00, b}, 16'h0000);
        acc(1'b1, TMC_OFS_CNT_LOW, 8'h34);
        acc(1'b1, TMC_OFS_CNT_HIGH, 8'h12);
        rdc;
        chk(v, 16'h1234);
        acc(1'b1, TMC_OFS_PRE_LOW, 8'h78);
        rdc;
        chk(v, 16'h1234);
        acc(1'b1, TMC_OFS_PRE_HIGH, 8'h56);
        rdc;
        chk(v, 16'h5678);
        $display("register test done");
    endtask
    task automatic t_timer;
        ld(16'hFFE0);
        acc(1'b1, TMC_OFS_CTRL, 8'h50);
        acc(1'b1, TMC_OFS_PRE_LOW, 8'h00);
        acc(1'b1, TMC_OFS_PRE_HIGH, 8'h80);
        acc(1'b0, TMC_OFS_CNT_HIGH, 8'h00);
        chk({8'h00, b}, 16'h00FF);
        acc(1'b0, TMC_OFS_CNT_LOW, 8'h00);
        w = {8'h00, b};
        repeat (3) @(posedge SYS_CLK);
        acc(1'b0, TMC_OFS_CNT_LOW, 8'h00);
        chk({8'h00, b}, w);
        for (int i = 0; i < 40 && flag !== 1'b1; i++) @(negedge SYS_CLK);
        @(posedge SYS_CLK);
        chk({15'h0000, flag}, 16'h0001);
        rdc;
        chk({8'h00, v[15:8]}, 16'h0080);
        chk({15'h0000, run}, 16'h0001);
        acc(1'b1, TMC_OFS_CTRL, 8'h40);
        rdc;
        w = v;
        repeat (5) @(posedge SYS_CLK);
        rdc;
        chk(v, w);
        acc(1'b1, TMC_OFS_IRQ, 8'h00);
        acc(1'b0, TMC_OFS_IRQ, 8'h00);
        chk({8'h00, b}, 16'h0000);
        $display("timer test done");
    endtask
    task automatic t_event;
        ld(16'h0000);
        acc(1'b1, TMC_OFS_CTRL, 8'h38);
        burst(1'b0, 4'h7, 8'h03);
        rdc;
        chk(v, 16'h0003);
        ld(16'h0000);
        acc(1'b1, TMC_OFS_CTRL, 8'h30);
        burst(1'b0, 4'h5, 8'h03);
        rdc;
        chk(v, 16'h0002);
        acc(1'b1, TMC_OFS_CFG, 8'h80);
        ld(16'h0000);
        acc(1'b1, TMC_OFS_CTRL, 8'h38);
        burst(1'b0, 4'h4, 8'h03);
        burst(1'b1, 4'h4, 8'h03);
        rdc;
        chk(v, 16'h0002);
        acc(1'b1, TMC_OFS_CFG, 8'h00);
        $display("event test done");
    endtask
    task automatic t_pulse;
        ld(16'hFFF0);
        acc(1'b1, TMC_OFS_CTRL, 8'h78);
        burst(1'b0, 4'h2, 8'h14);
        chk({15'h0000, run}, 16'h0000);
        chk({15'h0000, flag}, 16'h0001);
        rng(16'hFFF4);
        w = v;
        burst(1'b0, 4'h2, 8'h14);
        rdc;
        chk(v, w);
        acc(1'b1, TMC_OFS_IRQ, 8'h00);
        burst(1'b0, 4'h1, 8'h02);
        ld(16'h0000);
        acc(1'b1, TMC_OFS_CTRL, 8'h78);
        repeat (30) @(posedge SYS_CLK);
        burst(1'b0, 4'h3, 8'h08);
        rng(16'h0008);
        ld(16'h0000);
        acc(1'b1, TMC_OFS_CTRL, 8'h70);
        burst(1'b0, 4'h1, 8'h05);
        burst(1'b0, 4'h2, 8'h0C);
        rng(16'h000C);
        $display("pulse test done");
    endtask
    // converter mode: counter b on external rising edges, stop on counter a overflow
    task automatic t_adc;
        acc(1'b1, TMC_OFS_CFG, 8'h42);
        acc(1'b1, TMC_OFS_CNT_LOW, 8'h00);
        acc(1'b1, TMC_OFS_CNT_HIGH, 8'hFF);
        acc(1'b1, TMC_OFS_PRE_LOW, 8'h00);
        acc(1'b1, TMC_OFS_PRE_HIGH, 8'h00);
        acc(1'b1, TMC_OFS_CTRL, 8'h50);
        burst(1'b0, 4'h8, 8'h04);
        for (int i = 0; i < 300 && flag !== 1'b1; i++) @(negedge SYS_CLK);
        @(posedge SYS_CLK);
        chk({15'h0000, flag}, 16'h0001);
        chk({15'h0000, run}, 16'h0000);
        rdc;
        chk(v, 16'h0000);
        acc(1'b0, TMC_OFS_PRE_HIGH, 8'h00);
        w[15:8] = b;
        acc(1'b0, TMC_OFS_PRE_LOW, 8'h00);
        w[7:0] = b;
        chk(w, 16'h0004);
        acc(1'b1, TMC_OFS_CFG, 8'h00);
        acc(1'b1, TMC_OFS_IRQ, 8'h00);
        $display("converter test done");
    endtask
    // ========================================
    // verdict, watchdog and main sequence
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge SYS_CLK);
        RESETN <= 1'b1;
        @(posedge SYS_CLK);
        t_regs;
        t_timer;
        t_event;
        t_pulse;
        t_adc;
        give_verdict;
    end
endmodule // tmc_top_test
